// ==== tb_top.sv ====
// Self-checking bench for the link settings bank.
`timescale 1ns/1ps
`include "tsw_regs.svh"
module tb_top;
    import tsw_pkg::*;
    localparam int unsigned PC = 20;
    logic       i_clk;
    logic       i_rst;
    logic       hs_sel;
    logic       wr_en;
    logic [7:0] wr_addr;
    logic [7:0] wr_data;
    logic [7:0] rd_addr;
    logic [7:0] rd_data;
    logic [7:0] rv;
    logic       route_b;
    logic [3:0] term_a;
    logic [3:0] term_b;
    logic [3:0] eq_a;
    logic [3:0] eq_b;
    logic [1:0] pe;
    logic       oterm;
    logic       ocur;
    int         n_errors = 0;
    int         compares = 0;
    int         cyc = 0;

    tsw_link_settings #(.PULSE_CYCLES(PC)) i_dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_wr_en(wr_en),
        .i_wr_addr(wr_addr), .i_wr_data(wr_data), .i_rd_addr(rd_addr),
        .i_hs_source_sel(hs_sel), .o_rd_data(rd_data),
        .o_hs_route_b(route_b), .o_term_a(term_a), .o_term_b(term_b),
        .o_eq_high_a(eq_a), .o_eq_high_b(eq_b), .o_preemph_level(pe),
        .o_output_term_on(oterm), .o_out_current_sel(ocur)
    );

    tsw_host_model i_host (
        .i_clk(i_clk), .i_rd_data(rd_data), .o_wr_en(wr_en),
        .o_wr_addr(wr_addr), .o_wr_data(wr_data), .o_rd_addr(rd_addr)
    );

    initial i_clk = 1'b0;
    always #2.5 i_clk = ~i_clk;

    task automatic final_report;
        $display("compares=%0d mismatches=%0d", compares, n_errors);
        if (n_errors == 0 && compares > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : final_report

    // The run should need about 1550 cycles; this ceiling catches a hang.
    always @(posedge i_clk) begin
        cyc++;
        if (cyc == 8000) begin
            n_errors++;
            final_report();
        end
    end

    task automatic chk(input string nm, input logic [7:0] seen,
                       input logic [7:0] exp);
        compares++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    task automatic step(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask : step

    task automatic check_defaults;
        chk("route_b", route_b, 8'h00);
        chk("term_a", term_a, 8'h0f);
        chk("term_b", term_b, 8'h0f);
        chk("eq_a", eq_a, 8'h00);
        chk("eq_b", eq_b, 8'h00);
        chk("preemph", pe, 8'h00);
        chk("out_term", oterm, 8'h01);
        chk("out_cur", ocur, 8'h01);
        chk("rd_data", rd_data, 8'h00);
    endtask : check_defaults

    task automatic t_tx;
        for (int c = 0; c < 4; c++) begin
            i_host.wr(`TSW_ADDR_TX, {4'h0, c[1:0], 2'b11});
            step(2);
            chk("preemph", pe, {6'h00, c[1:0]});
            step(205);
        end
        i_host.wr(`TSW_ADDR_TX, 8'h0c);
        step(2);
        chk("out_term", oterm, 8'h00);
        chk("out_cur", ocur, 8'h00);
        step(5);
        i_host.wr(`TSW_ADDR_TX, 8'h03);
        step(5);
        i_host.wr(`TSW_ADDR_TX, 8'h07);
        step(150);
        chk("preemph", pe, 8'h03);
        chk("out_term", oterm, 8'h00);
        i_host.rd(`TSW_ADDR_TX, rv);
        chk("rd_tx", rv, 8'h07);
        step(50);
        chk("preemph", pe, 8'h01);
        chk("out_term", oterm, 8'h01);
        chk("out_cur", ocur, 8'h01);
        $display("test transmitter done");
    endtask : t_tx

    task automatic t_eq;
        i_host.wr(`TSW_ADDR_EQ, 8'h1e);
        step(2);
        chk("eq_a", eq_a, 8'h0e);
        chk("eq_b", eq_b, 8'h08);
        i_host.wr(`TSW_ADDR_EQ, 8'hff);
        step(2);
        chk("eq_b", eq_b, 8'h08);
        step(205);
        chk("eq_a", eq_a, 8'h0f);
        chk("eq_b", eq_b, 8'h0f);
        $display("test equalizer done");
    endtask : t_eq

    task automatic t_pulse;
        i_host.wr(`TSW_ADDR_PULSE, 8'h13);
        step(2);
        hs_sel = 1'b1;
        step(1);
        chk("route_b", route_b, 8'h01);
        step(2);
        chk("term_a", term_a, 8'h0c);
        chk("term_b", term_b, 8'h07);
        step(8);
        hs_sel = 1'b0;
        step(PC - 2);
        chk("term_a", term_a, 8'h0c);
        chk("term_b", term_b, 8'h07);
        step(PC);
        chk("term_a", term_a, 8'h0f);
        chk("term_b", term_b, 8'h0f);
        chk("route_b", route_b, 8'h00);
        $display("test pulse done");
    endtask : t_pulse

    task automatic t_term_off;
        i_host.wr(`TSW_ADDR_RX, 8'h00);
        step(2);
        chk("term_a", term_a, 8'h00);
        chk("term_b", term_b, 8'h00);
        hs_sel = 1'b1;
        step(4);
        chk("term_a", term_a, 8'h00);
        chk("term_b", term_b, 8'h00);
        step(205);
        i_host.wr(`TSW_ADDR_RX, 8'h01);
        step(2);
        chk("term_a", term_a, 8'h0f);
        chk("term_b", term_b, 8'h0f);
        $display("test termination off done");
    endtask : t_term_off

    task automatic t_unmapped;
        i_host.wr(8'h12, 8'h55);
        i_host.rd(8'h12, rv);
        chk("rd_unmapped", rv, 8'h00);
        i_host.rd(`TSW_ADDR_PULSE, rv);
        chk("rd_pulse", rv, 8'h13);
        $display("test unmapped done");
    endtask : t_unmapped

    task automatic t_midreset;
        hs_sel = 1'b0;
        i_rst  = 1'b1;
        step(2);
        i_rst  = 1'b0;
        step(1);
        check_defaults();
        $display("test mid-run reset done");
    endtask : t_midreset

    initial begin
        i_rst  = 1'b1;
        hs_sel = 1'b0;
        repeat (8) @(posedge i_clk);
        #1;
        i_rst = 1'b0;
        step(1);
        check_defaults();
        $display("test defaults done");
        t_tx();
        t_eq();
        t_pulse();
        t_term_off();
        t_unmapped();
        t_midreset();
        final_report();
    end
endmodule : tb_top

// ==== tsw_host_model.sv ====
// Register-port host that configures the link settings bank.
`timescale 1ns/1ps
module tsw_host_model (
    input  wire logic       i_clk,
    input  wire logic [7:0] i_rd_data,
    output logic            o_wr_en,
    output logic      [7:0] o_wr_addr,
    output logic      [7:0] o_wr_data,
    output logic      [7:0] o_rd_addr
);
    initial begin
        o_wr_en   = 1'b0;
        o_wr_addr = 8'h00;
        o_wr_data = 8'h00;
        o_rd_addr = 8'h00;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        o_wr_en   = 1'b1;
        o_wr_addr = a;
        o_wr_data = d;
        @(posedge i_clk);
        #1;
        o_wr_en   = 1'b0;
        // Released lines show garbage so a stale value is never relied on.
        o_wr_addr = ~a;
        o_wr_data = ~d;
    endtask : wr

    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        o_rd_addr = a;
        repeat (2) @(posedge i_clk);
        #1;
        d = i_rd_data;
    endtask : rd
endmodule : tsw_host_model

// ==== tsw_link_settings.sv ====
// Configuration bank for the high-speed path of a 2:1 video switch.
//
// How it works
// - Input termination bit low disconnects all inputs; high connects them.
// - On a source change, flagged channels disconnect for about 100 ms.
// - Pulse bits 0-3 are A0-A3, bits 4-7 are B3 down to B0.
// - Equalizer bit 0 selects 6 dB, 1 selects 12 dB, same order.
// - Two-bit pre-emphasis for all outputs: none, 2, 4, 6 dB.
// - One bit switches all output terminations off or on.
// - One bit sets output drive to 10 mA or 20 mA.
// - Defaults route input A, 6 dB, no pre-emphasis, terminations on.
// - Reset returns every setting to its default.
// - Writes apply at once in an idle window, else at its end; later writes don't restart it.
// - Source select picks A or B; its change starts pulsing while input terminations are on.
`timescale 1ns/1ps
`include "tsw_regs.svh"
module tsw_link_settings
    import tsw_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = `TSW_PULSE_CYC
) (
    input  wire logic       i_clk,
    input  wire logic       i_rst,
    input  wire logic       i_wr_en,
    input  wire logic [7:0] i_wr_addr,
    input  wire logic [7:0] i_wr_data,
    input  wire logic [7:0] i_rd_addr,
    input  wire logic       i_hs_source_sel,
    output logic      [7:0] o_rd_data,
    output logic            o_hs_route_b,
    output logic      [3:0] o_term_a,
    output logic      [3:0] o_term_b,
    output logic      [3:0] o_eq_high_a,
    output logic      [3:0] o_eq_high_b,
    output logic      [1:0] o_preemph_level,
    output logic            o_output_term_on,
    output logic            o_out_current_sel
);

    localparam int unsigned NREG = 4;

    // Bit 2 flags a mapped address; bits 1:0 give the storage index.
    function automatic logic [2:0] reg_index(input logic [7:0] addr);
        case (addr)
            `TSW_ADDR_RX:    reg_index = 3'b100;
            `TSW_ADDR_PULSE: reg_index = 3'b101;
            `TSW_ADDR_EQ:    reg_index = 3'b110;
            `TSW_ADDR_TX:    reg_index = 3'b111;
            default:         reg_index = 3'b000;
        endcase
    endfunction : reg_index

    function automatic tsw_byte_t rst_val(input int unsigned idx);
        case (idx)
            0:       rst_val = `TSW_RST_RX;
            1:       rst_val = `TSW_RST_PULSE;
            2:       rst_val = `TSW_RST_EQ;
            default: rst_val = `TSW_RST_TX;
        endcase
    endfunction : rst_val

    function automatic tsw_win_t win_len(input int unsigned idx);
        case (idx)
            0:       win_len = 16'(`TSW_NS_TO_CYC(`TSW_UPD_RX_NS));
            1:       win_len = 16'(`TSW_NS_TO_CYC(`TSW_UPD_PULSE_NS));
            2:       win_len = 16'(`TSW_NS_TO_CYC(`TSW_UPD_EQ_NS));
            default: win_len = 16'(`TSW_NS_TO_CYC(`TSW_UPD_TX_NS));
        endcase
    endfunction : win_len

    // Channel vectors are held A0..A3,B3..B0; this returns input B 3:0.
    function automatic logic [3:0] b_side(input tsw_byte_t v);
        b_side = {v[4], v[5], v[6], v[7]};
    endfunction : b_side

    tsw_byte_t  shadow_q [NREG];
    tsw_byte_t  shadow_d [NREG];
    tsw_byte_t  active_q [NREG];
    tsw_byte_t  active_d [NREG];
    tsw_win_t   win_q    [NREG];
    tsw_win_t   win_d    [NREG];
    logic [2:0] wr_idx;
    logic [2:0] rd_idx;
    tsw_byte_t  rd_d;
    tsw_byte_t  rd_q;

    assign wr_idx = reg_index(i_wr_addr);
    assign rd_idx = reg_index(i_rd_addr);

    // The readable value is the last one written, not the applied one.
    always_comb begin
        for (int unsigned i = 0; i < NREG; i++) begin
            shadow_d[i] = shadow_q[i];
            active_d[i] = active_q[i];
            win_d[i]    = (win_q[i] != 16'h0) ? win_q[i] - 16'h1 : 16'h0;
            if (i_wr_en && wr_idx[2] && (wr_idx[1:0] == 2'(i))) begin
                shadow_d[i] = i_wr_data;
                if (win_q[i] == 16'h0) begin
                    active_d[i] = i_wr_data;
                    win_d[i]    = win_len(i);
                end
            end
            if (win_q[i] == 16'h1) begin
                active_d[i] = shadow_d[i];
            end
        end
        rd_d = rd_idx[2] ? shadow_q[rd_idx[1:0]] : 8'h00;
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            for (int unsigned i = 0; i < NREG; i++) begin
                shadow_q[i] <= rst_val(i);
                active_q[i] <= rst_val(i);
                win_q[i]    <= 16'h0;
            end
            rd_q <= 8'h00;
        end else begin
            for (int unsigned i = 0; i < NREG; i++) begin
                shadow_q[i] <= shadow_d[i];
                active_q[i] <= active_d[i];
                win_q[i]    <= win_d[i];
            end
            rd_q <= rd_d;
        end
    end

    assign o_rd_data = rd_q;

    // Source tracking and termination state.
    tsw_pulse_if pif ();

    logic      term_on;
    logic      src_q;
    logic      src_d;
    tsw_byte_t term_q;
    tsw_byte_t term_d;

    assign term_on = active_q[0][`TSW_RX_TERM_BIT];

    // a change of select is the switch event
    assign pif.start = (i_hs_source_sel != src_q) && term_on;
    assign pif.mask  = active_q[1];

    always_comb begin
        src_d  = i_hs_source_sel;
        term_d = term_on ? ~pif.chan_off : 8'h00;
    end

    always_ff @(posedge i_clk) begin
        // default routes input A, terminations on
        if (i_rst) begin
            src_q  <= 1'b0;
            term_q <= 8'hff;
        end else begin
            src_q  <= src_d;
            term_q <= term_d;
        end
    end

    tsw_pulse_timer #(
        .PULSE_CYCLES (PULSE_CYCLES)
    ) u_pulse (
        .i_clk (i_clk),
        .i_rst (i_rst),
        .pif   (pif.timer)
    );

    assign o_hs_route_b      = src_q;
    assign o_term_a          = term_q[3:0];
    assign o_term_b          = b_side(term_q);
    assign o_eq_high_a       = active_q[2][3:0];
    assign o_eq_high_b       = b_side(active_q[2]);
    assign o_preemph_level   = active_q[3][`TSW_PREEMPH_LEVEL_MSB:`TSW_PREEMPH_LEVEL_LSB];
    assign o_output_term_on  = active_q[3][`TSW_OUTPUT_TERM_ON_BIT];
    assign o_out_current_sel = active_q[3][`TSW_OUT_CURRENT_SEL_BIT];

    // Checks.
    property p_term_off;
        @(posedge i_clk) disable iff (i_rst)
        !term_on |=> (o_term_a == 4'h0) && (o_term_b == 4'h0);
    endproperty
    a_term_off: assert property (p_term_off)
        else $error("Input terminations stayed on while disabled.");

    property p_pulse_drop;
        @(posedge i_clk) disable iff (i_rst)
        (pif.start && active_q[1][0] && term_on && $stable(active_q[0]))
            |=> ##1 !o_term_a[0];
    endproperty
    a_pulse_drop: assert property (p_pulse_drop)
        else $error("Channel A0 did not drop on a source change.");

    property p_b_order;
        @(posedge i_clk) disable iff (i_rst)
        1'b1 |-> (o_term_b[0] == term_q[7]) && (o_term_b[3] == term_q[4]);
    endproperty
    a_b_order: assert property (p_b_order)
        else $error("Input B channel order is not reversed.");

    property p_eq_map;
        @(posedge i_clk) disable iff (i_rst)
        1'b1 |-> (o_eq_high_b[0] == active_q[2][7])
                 && (o_eq_high_a == active_q[2][3:0]);
    endproperty
    a_eq_map: assert property (p_eq_map)
        else $error("Equalizer bits mapped to wrong channels.");

    property p_tx_apply;
        @(posedge i_clk) disable iff (i_rst)
        (i_wr_en && i_wr_addr == `TSW_ADDR_TX && win_q[3] == 16'h0)
            |=> (o_preemph_level == $past(i_wr_data[3:2]))
                && (o_out_current_sel == $past(i_wr_data[0]))
                && (o_output_term_on == $past(i_wr_data[1]));
    endproperty
    a_tx_apply: assert property (p_tx_apply)
        else $error("Transmitter write did not apply at once.");

    property p_defaults;
        @(posedge i_clk)
        i_rst |=> (o_eq_high_a == 4'h0) && (o_preemph_level == 2'b00)
                  && o_output_term_on && !o_hs_route_b
                  && (o_term_a == 4'hf) && (o_rd_data == 8'h00);
    endproperty
    a_defaults: assert property (p_defaults)
        else $error("Reset did not restore the default state.");

    property p_hold_in_window;
        @(posedge i_clk) disable iff (i_rst)
        (win_q[2] > 16'h1) |=> $stable(active_q[2]);
    endproperty
    a_hold_in_window: assert property (p_hold_in_window)
        else $error("Equalizer setting changed inside its window.");

    property p_window_end;
        @(posedge i_clk) disable iff (i_rst)
        (win_q[2] == 16'h1) |=> (active_q[2] == shadow_q[2]);
    endproperty
    a_window_end: assert property (p_window_end)
        else $error("Last written value not applied at window end.");

    property p_route;
        @(posedge i_clk) disable iff (i_rst)
        1'b1 |=> (o_hs_route_b == $past(i_hs_source_sel));
    endproperty
    a_route: assert property (p_route)
        else $error("Route does not follow the source select.");

    // The timer's own state is watched, so a wrong start gate is caught.
    property p_no_pulse_off;
        @(posedge i_clk) disable iff (i_rst)
        ((i_hs_source_sel != src_q) && !term_on && !pif.active)
            |=> !pif.active;
    endproperty
    a_no_pulse_off: assert property (p_no_pulse_off)
        else $error("Pulse started while terminations disabled.");

    property p_term_on;
        @(posedge i_clk) disable iff (i_rst)
        (term_on && (pif.chan_off == 8'h00))
            |=> (o_term_a == 4'hf) && (o_term_b == 4'hf);
    endproperty
    a_term_on: assert property (p_term_on)
        else $error("Input terminations stayed off while enabled.");

    property p_eq_apply;
        @(posedge i_clk) disable iff (i_rst)
        (i_wr_en && i_wr_addr == `TSW_ADDR_EQ && win_q[2] == 16'h0)
            |=> (o_eq_high_a == $past(i_wr_data[3:0]));
    endproperty
    a_eq_apply: assert property (p_eq_apply)
        else $error("Equalizer write in an idle window did not apply.");

    property p_tx_hold;
        @(posedge i_clk) disable iff (i_rst)
        (win_q[3] > 16'h1) |=> $stable(active_q[3]);
    endproperty
    a_tx_hold: assert property (p_tx_hold)
        else $error("Transmitter setting changed inside its window.");

endmodule : tsw_link_settings

// ==== tsw_pkg.sv ====
// Types shared by the link settings block and its pulse timer.
package tsw_pkg;

    typedef logic [7:0] tsw_byte_t;
    typedef logic [15:0] tsw_win_t;

    typedef enum logic [1:0] {
        TSW_IDLE  = 2'b01,
        TSW_PULSE = 2'b10
    } tsw_pulse_state_e;

endpackage : tsw_pkg

// ==== tsw_pulse_if.sv ====
// Interface between the settings bank and the termination pulse timer.
`timescale 1ns/1ps
interface tsw_pulse_if;
    logic       start;
    logic [7:0] mask;
    logic       active;
    logic [7:0] chan_off;

    modport ctrl  (output start, output mask, input active, input chan_off);
    modport timer (input start, input mask, output active, output chan_off);
endinterface : tsw_pulse_if

// ==== tsw_pulse_timer.sv ====
// Termination pulse timer: holds selected inputs disconnected.
`timescale 1ns/1ps
`include "tsw_regs.svh"
module tsw_pulse_timer
    import tsw_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = `TSW_PULSE_CYC
) (
    input  wire logic   i_clk,
    input  wire logic   i_rst,
    tsw_pulse_if.timer  pif
);

    tsw_pulse_state_e state_q;
    tsw_pulse_state_e state_d;
    logic [31:0]      cnt_q;
    logic [31:0]      cnt_d;
    logic [7:0]       off_q;
    logic [7:0]       off_d;

    always_comb begin
        state_d = state_q;
        cnt_d   = cnt_q;
        off_d   = off_q;
        if (pif.start) begin
            state_d = TSW_PULSE;
            cnt_d   = 32'(PULSE_CYCLES - 1);
            off_d   = pif.mask;
        end else begin
            case (state_q)
                TSW_IDLE: begin
                    off_d = 8'h00;
                end
                TSW_PULSE: begin
                    if (cnt_q == 32'h0) begin
                        state_d = TSW_IDLE;
                        off_d   = 8'h00;
                    end else begin
                        cnt_d = cnt_q - 32'h1;
                    end
                end
                default: begin
                    state_d = TSW_IDLE;
                    off_d   = 8'h00;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            state_q <= TSW_IDLE;
            cnt_q   <= 32'h0;
            off_q   <= 8'h00;
        end else begin
            state_q <= state_d;
            cnt_q   <= cnt_d;
            off_q   <= off_d;
        end
    end

    assign pif.active   = (state_q == TSW_PULSE);
    assign pif.chan_off = off_q;

    property p_pulse_load;
        @(posedge i_clk) disable iff (i_rst)
        pif.start |=> (off_q == $past(pif.mask))
                      && (cnt_q == 32'(PULSE_CYCLES - 1));
    endproperty
    a_pulse_load: assert property (p_pulse_load)
        else $error("Pulse did not load mask and full count.");

    property p_pulse_end;
        @(posedge i_clk) disable iff (i_rst)
        (pif.active && cnt_q == 32'h0 && !pif.start)
            |=> (!pif.active && off_q == 8'h00);
    endproperty
    a_pulse_end: assert property (p_pulse_end)
        else $error("Pulse did not end when its count ran out.");

endmodule : tsw_pulse_timer

// ==== tsw_regs.svh ====
// Register offsets, field positions, reset values and timing counts.
`ifndef TSW_REGS_SVH
`define TSW_REGS_SVH

`define TSW_ADDR_RX         8'h10
`define TSW_ADDR_PULSE      8'h11
`define TSW_ADDR_EQ         8'h13
`define TSW_ADDR_TX         8'h20

`define TSW_RST_RX          8'h01
`define TSW_RST_PULSE       8'h00
`define TSW_RST_EQ          8'h00
`define TSW_RST_TX          8'h03

`define TSW_RX_TERM_BIT     0
`define TSW_OUT_CURRENT_SEL_BIT      0
`define TSW_OUTPUT_TERM_ON_BIT      1
`define TSW_PREEMPH_LEVEL_LSB       2
`define TSW_PREEMPH_LEVEL_MSB       3

`define TSW_CLK_MHZ         200
`define TSW_PULSE_MS        100
`define TSW_PULSE_CYC       (`TSW_PULSE_MS * 1000 * `TSW_CLK_MHZ)

`define TSW_UPD_RX_NS       1000
`define TSW_UPD_PULSE_NS    1000
`define TSW_UPD_EQ_NS       1000
`define TSW_UPD_TX_NS       1000
`define TSW_NS_TO_CYC(ns)   (((ns) * `TSW_CLK_MHZ + 999) / 1000)

`endif
